// ===== pkg/sixic_pkg.sv
// Constants, carrier structs and state types of the six source interrupt controller
package sixic_pkg;
   localparam int SIXIC_NSRC = 6;
   localparam logic [7:0] SIXIC_ADDR_REQ = 8'hFA;
   localparam logic [7:0] SIXIC_ADDR_MASK = 8'hFB;
   localparam logic [7:0] SIXIC_REQ_RST = 8'h00;
   localparam logic [7:0] SIXIC_MASK_RST = 8'h00;
   localparam int SIXIC_MASTER_BIT = 7;
   localparam logic [7:0] SIXIC_VEC_BASE = 8'h02;
   localparam logic [2:0] SIXIC_ARM_FULL = 3'h7;

   // Register file access from the instruction sequencer
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sixic_regbus_t;

   // Interrupt related instruction strobes and acknowledge
   typedef struct packed {
      logic enable_interrupts_instruction;
      logic disable_interrupts_instruction;
      logic return_from_interrupt_instruction;
      logic ack;
   } sixic_core_t;

   typedef struct packed {
      logic [7:0] req;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic pend;
      logic [2:0] lvl;
      logic [7:0] vec;
   } sixic_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [2:0] arm;
      logic rise;
      logic fall;
   } sixic_edge_t;
endpackage

// ===== rtl/sixic_edge_sync.sv
// Pin synchroniser with rise and fall pulse detection
`timescale 1ns/10ps
module sixic_edge_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Asynchronous pin
   input wire logic pin,
   // One-cycle edge pulses
   output logic rise,
   output logic fall
);
   import sixic_pkg::*;

   sixic_edge_t r_reg;
   sixic_edge_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.s1 = pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.arm = {r_reg.arm[1:0], 1'b1};
      // Edges only count once s3 holds a real pin sample, so reset never fakes one
      r_next.rise = r_reg.arm[2] & r_reg.s2 & ~r_reg.s3;
      r_next.fall = r_reg.arm[2] & ~r_reg.s2 & r_reg.s3;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rise = r_reg.rise;
   assign fall = r_reg.fall;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_one_edge;
      !(rise && fall) and (rise |=> !rise) and (fall |=> !fall);
   endproperty
   a_one_edge: assert property (p_one_edge) else $error("edge pulse repeated or doubled");
endmodule

// ===== rtl/sixic_top.sv
// Six source prioritised interrupt controller with request and mask registers
`timescale 1ns/10ps
module sixic_top (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Register file access
   input wire sixic_pkg::sixic_regbus_t regbus,
   output logic [7:0] reg_rdata,
   // Instruction strobes from the core
   input wire sixic_pkg::sixic_core_t core,
   // Sources
   input wire logic [2:0] timer_timeout,
   input wire logic [2:0] timer_irq_enable,
   input wire logic port_b_pin_four,
   input wire logic port_b_pin_two,
   // Towards the core
   output logic irq_pending,
   output logic [2:0] irq_level,
   output logic [7:0] vector_location
);
   import sixic_pkg::*;

   localparam sixic_state_t RST_STATE = '{req: SIXIC_REQ_RST, mask: SIXIC_MASK_RST, rdata: 8'h00,
                                         pend: 1'b0, lvl: 3'h0, vec: SIXIC_VEC_BASE};

   sixic_state_t r_reg;
   sixic_state_t r_next;
   logic b4_rise;
   logic b4_fall;
   logic b2_rise;
   logic b2_fall;
   logic [5:0] hw_set;
   logic wr_req;
   logic wr_mask;
   logic take_ack;

   // Lowest set index wins: index 0 is the highest priority
   function automatic logic [3:0] first_pending(input logic [5:0] v);
      logic [3:0] res;
      res = 4'h0;
      for (int i = SIXIC_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            res = {1'b1, 3'(i)};
         end
      end
      return res;
   endfunction

   sixic_edge_sync u_pin_four (
      .clock(clock),
      .resetn(resetn),
      .pin(port_b_pin_four),
      .rise(b4_rise),
      .fall(b4_fall)
   );

   sixic_edge_sync u_pin_two (
      .clock(clock),
      .resetn(resetn),
      .pin(port_b_pin_two),
      .rise(b2_rise),
      .fall(b2_fall)
   );

   // Timers report only when configured; pin four edges and pin two falls always report, pin two rises are unused
   assign hw_set[0] = timer_timeout[0] & timer_irq_enable[0];
   assign hw_set[1] = b4_fall;
   assign hw_set[2] = timer_timeout[1] & timer_irq_enable[1];
   assign hw_set[3] = b2_fall;
   assign hw_set[4] = b4_rise;
   assign hw_set[5] = timer_timeout[2] & timer_irq_enable[2];

   assign wr_req = regbus.wr && (regbus.addr == SIXIC_ADDR_REQ);
   assign wr_mask = regbus.wr && (regbus.addr == SIXIC_ADDR_MASK);
   assign take_ack = core.ack && r_reg.pend;

   always_comb begin
      logic [3:0] sel;
      sel = 4'h0;
      r_next = r_reg;
      if (take_ack) begin
         r_next.req[r_reg.lvl] = 1'b0;
      end
      // A source event beats the acknowledge clear of the same bit
      r_next.req = r_next.req | {2'b00, hw_set};
      if (wr_req) begin
         r_next.req = regbus.wdata;
      end
      if (wr_mask) begin
         r_next.mask = regbus.wdata;
      end
      if (core.enable_interrupts_instruction || core.return_from_interrupt_instruction) begin
         r_next.mask[SIXIC_MASTER_BIT] = 1'b1;
      end
      // Disable and service entry win, so an interrupted sequence stays closed
      if (core.disable_interrupts_instruction || take_ack) begin
         r_next.mask[SIXIC_MASTER_BIT] = 1'b0;
      end
      sel = first_pending(r_next.req[5:0] & r_next.mask[5:0]);
      r_next.pend = r_next.mask[SIXIC_MASTER_BIT] & sel[3];
      r_next.lvl = sel[2:0];
      r_next.vec = SIXIC_VEC_BASE + {4'h0, sel[2:0], 1'b0};
      r_next.rdata = 8'h00;
      if (regbus.rd && regbus.addr == SIXIC_ADDR_REQ) begin
         r_next.rdata = r_reg.req;
      end else if (regbus.rd && regbus.addr == SIXIC_ADDR_MASK) begin
         r_next.rdata = r_reg.mask;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         r_reg <= RST_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;
   assign irq_pending = r_reg.pend;
   assign irq_level = r_reg.lvl;
   assign vector_location = r_reg.vec;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   logic [5:0] armed;
   logic [5:0] higher;
   assign armed = r_reg.req[5:0] & r_reg.mask[5:0];
   assign higher = armed & ((6'h01 << r_reg.lvl) - 6'h01);

   property p_vector;
      irq_pending |-> vector_location == SIXIC_VEC_BASE + {4'h0, irq_level, 1'b0} && armed[irq_level];
   endproperty
   a_vector: assert property (p_vector) else $error("vector does not match level");

   property p_prio;
      irq_pending |-> higher == 6'h00;
   endproperty
   a_prio: assert property (p_prio) else $error("higher priority request skipped");

   property p_master;
      irq_pending == (r_reg.mask[SIXIC_MASTER_BIT] && armed != 6'h00);
   endproperty
   a_master: assert property (p_master) else $error("pending disagrees with master and mask");

   property p_enable;
      core.enable_interrupts_instruction && !core.disable_interrupts_instruction && !take_ack
         |=> r_reg.mask[SIXIC_MASTER_BIT];
   endproperty
   a_enable: assert property (p_enable) else $error("enable instruction failed");

   property p_disable;
      core.disable_interrupts_instruction |=> !r_reg.mask[SIXIC_MASTER_BIT] ##0 !irq_pending;
   endproperty
   a_disable: assert property (p_disable) else $error("disable instruction failed");

   sequence s_service;
      take_ack && !wr_req && hw_set == 6'h00
         && !core.enable_interrupts_instruction && !core.return_from_interrupt_instruction;
   endsequence
   // The cleared level is the one shown when the acknowledge was taken
   sequence s_closed;
      !r_reg.req[$past(irq_level)] && !r_reg.mask[SIXIC_MASTER_BIT] && !irq_pending;
   endsequence
   property p_ack;
      s_service |=> s_closed;
   endproperty
   a_ack: assert property (p_ack) else $error("service entry did not clear bit and master");

   // An acknowledge with nothing pending is refused and leaves the flags alone
   property p_ack_idle;
      core.ack && !irq_pending && !wr_req && hw_set == 6'h00 |=> r_reg.req == $past(r_reg.req);
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("acknowledge taken with nothing pending");

   property p_return;
      core.return_from_interrupt_instruction && !core.disable_interrupts_instruction && !take_ack
         |=> r_reg.mask[SIXIC_MASTER_BIT];
   endproperty
   a_return: assert property (p_return) else $error("return did not reopen master");

   property p_swwin;
      wr_req |=> r_reg.req == $past(regbus.wdata);
   endproperty
   a_swwin: assert property (p_swwin) else $error("software write lost to hardware");

   // Every source event lands unless a software write owns that cycle
   property p_srcset;
      hw_set != 6'h00 && !wr_req |=> (r_reg.req[5:0] & $past(hw_set)) == $past(hw_set);
   endproperty
   a_srcset: assert property (p_srcset) else $error("source event not recorded");

   property p_hwset;
      hw_set[0] && !wr_req |=> r_reg.req[0] && (irq_pending || !r_reg.mask[0] || !r_reg.mask[SIXIC_MASTER_BIT]);
   endproperty
   a_hwset: assert property (p_hwset) else $error("timer request not recorded");

   property p_reset;
      disable iff (1'b0) !resetn |=> r_reg.req == SIXIC_REQ_RST && r_reg.mask == SIXIC_MASK_RST && !irq_pending;
   endproperty
   a_reset: assert property (p_reset) else $error("registers not cleared by reset");
endmodule

// ===== verif/sixic_src_model.sv
// Source model: timer time-outs and port pins
`timescale 1ns/10ps
module sixic_src_model (
   // Clock
   input wire logic clock,
   // Sources
   output logic [2:0] timer_timeout,
   output logic [2:0] timer_irq_enable,
   output logic port_b_pin_four,
   output logic port_b_pin_two
);
   initial begin
      timer_timeout = 3'h0;
      timer_irq_enable = 3'h0;
      port_b_pin_four = 1'b1;
      port_b_pin_two = 1'b1;
   end
   task automatic tick(input int i, input logic en);
      @(posedge clock);
      timer_timeout[i] <= 1'b1;
      timer_irq_enable[i] <= en;
      @(posedge clock);
      timer_timeout[i] <= 1'b0;
   endtask
   // Levels held well past the synchroniser depth
   task automatic pins(input logic p4, input logic p2);
      @(posedge clock);
      port_b_pin_four <= p4;
      port_b_pin_two <= p2;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the six source interrupt controller
`timescale 1ns/10ps
module testbench;
   import sixic_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   sixic_regbus_t regbus = '0;
   sixic_core_t core = '0;
   logic [7:0] reg_rdata, vector_location, r, left;
   logic irq_pending, p4, p2;
   logic rd_seen = 1'b0;
   logic [2:0] irq_level, tmo, ten;
   logic [7:0] exp_q[$];
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   always #25 clock = ~clock;
   sixic_src_model src (.clock(clock), .timer_timeout(tmo), .timer_irq_enable(ten),
      .port_b_pin_four(p4), .port_b_pin_two(p2));
   sixic_top DUT (.clock(clock), .resetn(resetn), .regbus(regbus), .reg_rdata(reg_rdata),
      .core(core), .timer_timeout(tmo), .timer_irq_enable(ten), .port_b_pin_four(p4),
      .port_b_pin_two(p2), .irq_pending(irq_pending), .irq_level(irq_level),
      .vector_location(vector_location));
   task automatic give_verdict();
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   always @(posedge clock) begin
      rd_seen <= regbus.rd;
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   // Read data lands on the same edge that takes the strobe
   always @(negedge clock) begin
      if (rd_seen) cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regbus.wr <= 1'b1;
      regbus.addr <= a;
      regbus.wdata <= d;
      @(posedge clock);
      regbus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      regbus.rd <= 1'b1;
      regbus.addr <= a;
      exp_q.push_back(e);
      @(posedge clock);
      regbus.rd <= 1'b0;
      @(posedge clock);
   endtask
   // Bit order is enable, disable, return, acknowledge
   task automatic strobe(input logic [3:0] m);
      @(posedge clock);
      core <= sixic_core_t'(m);
      @(posedge clock);
      core <= '0;
   endtask
   task automatic irq(input logic p, input logic [2:0] l);
      repeat (2) @(posedge clock);
      @(negedge clock);
      cmp("irq_pending", {7'h00, p}, {7'h00, irq_pending});
      if (p) begin
         cmp("irq_level", {5'h00, l}, {5'h00, irq_level});
         cmp("vector_location", SIXIC_VEC_BASE + {4'h0, l, 1'b0}, vector_location);
      end
   endtask
   function automatic logic [2:0] low(input logic [7:0] v);
      low = 3'h0;
      for (int b = 5; b >= 0; b--) if (v[b]) low = 3'(b);
   endfunction
   initial begin
      void'($urandom(72));
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      rd(SIXIC_ADDR_REQ, SIXIC_REQ_RST);
      rd(SIXIC_ADDR_MASK, SIXIC_MASK_RST);
      wr(8'hFC, 8'hFF);
      rd(8'hFC, 8'h00);
      for (int i = 0; i < 6; i++) begin
         r = (8'($urandom) & 8'h3F) & (8'hFF << i) | (8'h01 << i);
         wr(SIXIC_ADDR_REQ, r);
         wr(SIXIC_ADDR_MASK, 8'h3F);
         irq(1'b0, 3'h0);
         strobe(4'h8);
         irq(1'b1, 3'(i));
         strobe(4'h1);
         irq(1'b0, 3'h0);
         left = r & ~(8'h01 << i);
         rd(SIXIC_ADDR_REQ, left);
         rd(SIXIC_ADDR_MASK, 8'h3F);
         strobe(4'h2);
         irq(left != 8'h00, low(left));
         strobe(4'h4);
         irq(1'b0, 3'h0);
         strobe(4'h1);
         rd(SIXIC_ADDR_REQ, left);
      end
      wr(SIXIC_ADDR_REQ, 8'hFF);
      wr(SIXIC_ADDR_MASK, 8'h3E);
      strobe(4'h8);
      irq(1'b1, 3'h1);
      strobe(4'h4);
      wr(SIXIC_ADDR_REQ, 8'hC0);
      rd(SIXIC_ADDR_REQ, 8'hC0);
      strobe(4'h8);
      irq(1'b0, 3'h0);
      strobe(4'h4);
      wr(SIXIC_ADDR_REQ, 8'h00);
      for (int t = 0; t < 3; t++) begin
         src.tick(t, 1'b0);
         src.tick(t, 1'b1);
      end
      rd(SIXIC_ADDR_REQ, 8'h25);
      wr(SIXIC_ADDR_REQ, 8'h00);
      src.pins(1'b0, 1'b1);
      src.pins(1'b1, 1'b0);
      src.pins(1'b1, 1'b1);
      rd(SIXIC_ADDR_REQ, 8'h1A);
      fork
         wr(SIXIC_ADDR_REQ, 8'h00);
         src.tick(0, 1'b1);
      join
      rd(SIXIC_ADDR_REQ, 8'h00);
      // A reset in mid-run must clear registers that hold live values
      wr(SIXIC_ADDR_REQ, 8'h3F);
      wr(SIXIC_ADDR_MASK, 8'h3F);
      strobe(4'h8);
      irq(1'b1, 3'h0);
      @(posedge clock);
      resetn <= 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      irq(1'b0, 3'h0);
      rd(SIXIC_ADDR_REQ, SIXIC_REQ_RST);
      rd(SIXIC_ADDR_MASK, SIXIC_MASK_RST);
      give_verdict();
   end
endmodule
